/* rtl/lid_pkg.sv */
/*
  Constants shared by the LCD instruction decoder, its job buffer and its display RAM.
  Assumes one 20 MHz clock (50 ns period) and a synchronous, active-high reset.
*/
// How it works
// - select-high write picks a 4-bit instruction; select-low write executes it.
// - code 02h loads row length, byte is characters per row minus one.
// - horizontal dot count equals horizontal pitch times characters per row.
// - code 03h loads duty divisor minus one; divisors 1 to 256 accepted.
// - code 04h loads cursor line minus one in the low four bits.
// - cursor drawn, with priority, only when cursor line is within vertical pitch.
// - codes 08h and 09h load low and high display start address bytes.
// - codes 0Ah and 0Bh load low and high bytes of cursor counter.
// - cursor counter counts up; low bit 7 falling carries into high byte.
// - code 0Ch data writes store to RAM at cursor, then counter increments.
// - code 0Dh reads return output latch, then latch reloads from RAM, counter increments.
// - codes 0Eh/0Fh clear/set bit index at cursor byte, then counter increments.
// - select-high read returns busy flag on the data msb without instruction.
// - busy high while executing; new data writes and reads refused while busy.
// - instruction register writes leave the busy flag unchanged.
package lid_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 4;
    localparam int ADDR_W = 16;
    localparam int DOTS_W = 12;
    localparam int JOB_W = 1 + INSTR_W + DATA_W;

    localparam logic [INSTR_W-1:0] CODE_ROW_LENGTH = 4'h2;
    localparam logic [INSTR_W-1:0] CODE_DUTY = 4'h3;
    localparam logic [INSTR_W-1:0] CODE_CURSOR_LINE = 4'h4;
    localparam logic [INSTR_W-1:0] CODE_START_LOW = 4'h8;
    localparam logic [INSTR_W-1:0] CODE_START_HIGH = 4'h9;
    localparam logic [INSTR_W-1:0] CODE_CURSOR_LOW = 4'hA;
    localparam logic [INSTR_W-1:0] CODE_CURSOR_HIGH = 4'hB;
    localparam logic [INSTR_W-1:0] CODE_RAM_WRITE = 4'hC;
    localparam logic [INSTR_W-1:0] CODE_RAM_READ = 4'hD;
    localparam logic [INSTR_W-1:0] CODE_BIT_CLEAR = 4'hE;
    localparam logic [INSTR_W-1:0] CODE_BIT_SET = 4'hF;

    localparam logic [INSTR_W-1:0] RESET_INSTR = 4'h0;
    localparam logic [DATA_W-1:0] RESET_ROW_LENGTH = 8'h00;
    localparam logic [DATA_W-1:0] RESET_DUTY = 8'h00;
    localparam logic [3:0] RESET_CURSOR_LINE = 4'h0;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
    localparam logic [DATA_W-1:0] RESET_DATA = 8'h00;

    localparam int BUSY_BIT = 7;
    localparam int CURSOR_LINE_BITS = 4;
    localparam int BIT_INDEX_BITS = 3;
    localparam int SYNC_STAGES = 2;
endpackage : lid_pkg

/* rtl/lid_job_buffer.sv */
/*
  Two-entry job buffer with valid/ready on both sides.
  Assumes the same clock and reset as its user; no pass-through when empty.
*/
`timescale 1ns/1ps
module lid_job_buffer #(
    parameter int WIDTH = 13
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    logic [WIDTH-1:0] slot [0:1];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    wire push = i_in_valid && (count != 2'h2);
    wire pop = (count != 2'h0) && i_out_ready;

    assign o_in_ready = (count != 2'h2);
    assign o_out_valid = (count != 2'h0);
    assign o_out_data = slot[rd_ptr];

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot[wr_ptr] <= i_in_data;
        end
    end
endmodule : lid_job_buffer

/* rtl/lid_display_ram.sv */
/*
  Display RAM: one byte per cursor address, synchronous read one cycle after the address.
  Assumes a single clock; contents are undefined after power-up.
*/
`timescale 1ns/1ps
module lid_display_ram (
    input wire logic i_clk,
    input wire logic [lid_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_write,
    input wire logic [lid_pkg::DATA_W-1:0] i_wdata,
    output logic [lid_pkg::DATA_W-1:0] o_rdata
);
    import lid_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge i_clk) begin
        if (i_write) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : lid_display_ram

/* rtl/lid_instruction_decoder.sv */
/*
  Host command interpreter of the LCD controller: instruction register, setting registers,
  cursor address counter, RAM write/read/bit operations and the busy flag.
  Assumes host pins (strobe, select, direction, data) are asynchronous to i_clk; the data
  bus is resolved outside from o_data and o_data_oe. Pitch and mode come from mode logic.
*/
`timescale 1ns/1ps
module lid_instruction_decoder (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_strobe,
    input wire logic i_register_select_line,
    input wire logic i_read_not_write,
    input wire logic [lid_pkg::DATA_W-1:0] i_data,
    output logic [lid_pkg::DATA_W-1:0] o_data,
    output logic o_data_oe,
    input wire logic [3:0] i_horizontal_pitch,
    input wire logic [3:0] i_vertical_pitch,
    input wire logic i_char_mode,
    input wire logic i_cursor_enable,
    output logic [lid_pkg::DATA_W-1:0] o_row_length,
    output logic [lid_pkg::DATA_W-1:0] o_duty_divisor,
    output logic [3:0] o_cursor_line,
    output logic [lid_pkg::ADDR_W-1:0] o_start_address,
    output logic [lid_pkg::ADDR_W-1:0] o_cursor_address,
    output logic [lid_pkg::DOTS_W-1:0] o_dot_count,
    output logic o_cursor_visible,
    output logic o_busy
);
    import lid_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_BIT_MODIFY = 4'b0010,
        S_FETCH = 4'b0100,
        S_SETTLE = 4'b1000
    } lid_state_t;

    function automatic logic [ADDR_W-1:0] lid_advance(input logic [ADDR_W-1:0] addr);
        lid_advance = addr + 16'h0001;
    endfunction : lid_advance

    function automatic logic [DATA_W-1:0] lid_bit_mask(input logic [BIT_INDEX_BITS-1:0] idx);
        lid_bit_mask = 8'h01 << idx;
    endfunction : lid_bit_mask

    // pin synchronisers: first stage feeds only the second
    logic [SYNC_STAGES-1:0] strobe_sync;
    logic [SYNC_STAGES-1:0] select_sync;
    logic [SYNC_STAGES-1:0] dir_sync;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic strobe_prev;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            strobe_sync <= '0;
            select_sync <= '0;
            dir_sync <= '0;
            data_meta <= RESET_DATA;
            data_sync <= RESET_DATA;
            strobe_prev <= 1'b0;
        end else begin
            strobe_sync <= {strobe_sync[0], i_strobe};
            select_sync <= {select_sync[0], i_register_select_line};
            dir_sync <= {dir_sync[0], i_read_not_write};
            data_meta <= i_data;
            data_sync <= data_meta;
            strobe_prev <= strobe_sync[1];
        end
    end

    wire strobe_s = strobe_sync[1];
    wire select_s = select_sync[1];
    wire dir_s = dir_sync[1];
    // writes latch on the strobe's falling edge, reads open on its rising edge
    wire write_event = strobe_prev && !strobe_s && !dir_s;
    wire read_event = !strobe_prev && strobe_s && dir_s;

    logic [INSTR_W-1:0] instr;
    logic busy_flag;
    logic [DATA_W-1:0] out_latch;
    lid_state_t state;
    lid_state_t next_state;
    logic [JOB_W-1:0] job;
    logic [ADDR_W-1:0] cursor;

    wire instr_write = write_event && select_s;
    wire data_write = write_event && !select_s;
    wire status_read = read_event && select_s;
    wire data_read = read_event && !select_s;

    wire job_in_ready;
    wire job_valid;
    wire [JOB_W-1:0] job_head;
    // while busy nothing new is queued; the buffer still stalls the push on its own ready
    wire push_write = data_write && !busy_flag && job_in_ready;
    wire push_read = data_read && !busy_flag && job_in_ready
        && (instr == CODE_RAM_READ);
    wire job_push = push_write || push_read;
    wire [JOB_W-1:0] job_new = {push_read, instr, data_sync};
    wire job_pop = (state == S_IDLE) && job_valid;

    lid_job_buffer #(
        .WIDTH(JOB_W)
    ) u_job_buffer (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(job_push),
        .o_in_ready(job_in_ready),
        .i_in_data(job_new),
        .o_out_valid(job_valid),
        .i_out_ready(job_pop),
        .o_out_data(job_head)
    );

    wire head_is_read = job_head[JOB_W-1];
    wire [INSTR_W-1:0] head_code = job_head[DATA_W +: INSTR_W];
    wire [DATA_W-1:0] head_data = job_head[DATA_W-1:0];
    wire [DATA_W-1:0] job_data = job[DATA_W-1:0];
    wire [INSTR_W-1:0] job_code = job[DATA_W +: INSTR_W];

    wire start_ram_write = job_pop && !head_is_read && head_code == CODE_RAM_WRITE;
    wire start_fetch = job_pop && head_is_read;
    wire start_bit = job_pop && !head_is_read
        && (head_code == CODE_BIT_CLEAR || head_code == CODE_BIT_SET);

    wire [DATA_W-1:0] ram_rdata;
    wire [DATA_W-1:0] bit_mask = lid_bit_mask(job_data[BIT_INDEX_BITS-1:0]);
    wire [DATA_W-1:0] bit_result = (job_code == CODE_BIT_SET) ?
        (ram_rdata | bit_mask) : (ram_rdata & ~bit_mask);
    wire ram_write = start_ram_write || state == S_BIT_MODIFY;
    wire [DATA_W-1:0] ram_wdata = (state == S_BIT_MODIFY) ? bit_result : head_data;

    lid_display_ram u_display_ram (
        .i_clk(i_clk),
        .i_addr(cursor),
        .i_write(ram_write),
        .i_wdata(ram_wdata),
        .o_rdata(ram_rdata)
    );

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (start_bit) begin
                    next_state = S_BIT_MODIFY;
                end else if (start_fetch) begin
                    next_state = S_FETCH;
                end
            end
            S_BIT_MODIFY: next_state = S_SETTLE;
            S_FETCH: next_state = S_SETTLE;
            S_SETTLE: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // counter advances once per RAM job; low-byte load may carry into the high byte
    wire low_load = job_pop && !head_is_read && head_code == CODE_CURSOR_LOW;
    wire high_load = job_pop && !head_is_read && head_code == CODE_CURSOR_HIGH;
    wire low_carry = cursor[DATA_W-1] && !head_data[DATA_W-1];
    wire advance = start_ram_write || state == S_BIT_MODIFY || state == S_FETCH;
    wire [ADDR_W-1:0] next_cursor = low_load ?
        {cursor[ADDR_W-1:DATA_W] + {7'h00, low_carry}, head_data} :
        high_load ? {head_data, cursor[DATA_W-1:0]} :
        advance ? lid_advance(cursor) : cursor;

    wire next_busy = job_push || job_valid || (next_state != S_IDLE)
        || (state != S_IDLE);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            instr <= RESET_INSTR;
            state <= S_IDLE;
            job <= '0;
            cursor <= RESET_ADDR;
            busy_flag <= 1'b0;
            out_latch <= RESET_DATA;
        end else begin
            if (instr_write) begin
                instr <= data_sync[INSTR_W-1:0];
            end
            state <= next_state;
            if (job_pop) begin
                job <= job_head;
            end
            cursor <= next_cursor;
            busy_flag <= next_busy;
            if (state == S_FETCH) begin
                out_latch <= ram_rdata;
            end
        end
    end

    // setting registers; undefined codes fall through untouched
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_row_length <= RESET_ROW_LENGTH;
            o_duty_divisor <= RESET_DUTY;
            o_cursor_line <= RESET_CURSOR_LINE;
            o_start_address <= RESET_ADDR;
        end else if (job_pop && !head_is_read) begin
            case (head_code)
                CODE_ROW_LENGTH: o_row_length <= head_data;
                CODE_DUTY: o_duty_divisor <= head_data;
                CODE_CURSOR_LINE: o_cursor_line <= head_data[CURSOR_LINE_BITS-1:0];
                CODE_START_LOW: o_start_address[DATA_W-1:0] <= head_data;
                CODE_START_HIGH: o_start_address[ADDR_W-1:DATA_W] <= head_data;
                default: o_row_length <= o_row_length;
            endcase
        end
    end

    // host read port: data held while the strobe stays high
    wire [DATA_W-1:0] status_byte = {busy_flag, 7'h00};
    wire [DATA_W-1:0] read_byte = select_s ? status_byte : out_latch;
    wire [DOTS_W-1:0] row_chars = {4'h0, o_row_length} + 12'h001;
    wire [DOTS_W-1:0] dots = row_chars * {8'h00, i_horizontal_pitch};
    // both fields hold value minus one, so the compare is unchanged
    wire cursor_fits = o_cursor_line <= i_vertical_pitch;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_data <= RESET_DATA;
            o_data_oe <= 1'b0;
            o_cursor_address <= RESET_ADDR;
            o_dot_count <= '0;
            o_cursor_visible <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            if (status_read || data_read) begin
                o_data <= read_byte;
            end
            o_data_oe <= strobe_s && dir_s;
            o_cursor_address <= cursor;
            o_dot_count <= dots;
            o_cursor_visible <= i_char_mode && i_cursor_enable && cursor_fits;
            o_busy <= busy_flag;
        end
    end
endmodule : lid_instruction_decoder

/* bench/lid_props.sv */
/* Port checker for the instruction decoder, bound after the module.
   Assumes one clock and the decoder's synchronous active-high reset. */
`timescale 1ns/1ps
module lid_props (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_strobe,
    input wire logic i_register_select_line,
    input wire logic i_read_not_write,
    input wire logic [lid_pkg::DATA_W-1:0] o_data,
    input wire logic o_data_oe,
    input wire logic [3:0] i_horizontal_pitch,
    input wire logic [3:0] i_vertical_pitch,
    input wire logic i_char_mode,
    input wire logic i_cursor_enable,
    input wire logic [lid_pkg::DATA_W-1:0] o_row_length,
    input wire logic [lid_pkg::DATA_W-1:0] o_duty_divisor,
    input wire logic [3:0] o_cursor_line,
    input wire logic [lid_pkg::ADDR_W-1:0] o_start_address,
    input wire logic [lid_pkg::ADDR_W-1:0] o_cursor_address,
    input wire logic [lid_pkg::DOTS_W-1:0] o_dot_count,
    input wire logic o_cursor_visible,
    input wire logic o_busy
);
    import lid_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    chk_status_low_zero: assert property (
        $rose(o_data_oe) && i_register_select_line && i_read_not_write |-> o_data[6:0] == 7'h00)
        else $error("status read low bits not zero");
    // three stable samples: outputs may lag the settings by a cycle
    chk_dot_count_product: assert property (
        ($stable(o_row_length) && $stable(i_horizontal_pitch)) [*3]
        |-> o_dot_count == {8'h00, i_horizontal_pitch} * ({4'h0, o_row_length} + 12'h001))
        else $error("dot count wrong");
    chk_cursor_shown_rule: assert property (
        $stable({o_cursor_line, i_vertical_pitch, i_char_mode, i_cursor_enable}) [*3]
        |-> o_cursor_visible == (i_char_mode && i_cursor_enable
        && o_cursor_line <= i_vertical_pitch))
        else $error("cursor visibility wrong");
    chk_busy_clears: assert property ($rose(o_busy) |-> ##[1:16] !o_busy)
        else $error("busy stuck high");
    chk_cursor_moves_busy: assert property (
        $changed(o_cursor_address) |-> o_busy || $past(o_busy))
        else $error("cursor changed while idle");
    chk_setting_moves_busy: assert property (
        $changed({o_row_length, o_duty_divisor, o_cursor_line, o_start_address})
        |-> ##[0:2] o_busy)
        else $error("setting changed without busy");
    chk_drive_on_read: assert property (
        $rose(o_data_oe) |-> i_strobe && i_read_not_write)
        else $error("bus driven outside a read");
    chk_read_data_holds: assert property (
        o_data_oe && $past(o_data_oe) |-> $stable(o_data))
        else $error("read data changed mid-read");
    chk_bus_released: assert property (!i_strobe [*6] |-> !o_data_oe)
        else $error("bus still driven");
endmodule : lid_props

bind lid_instruction_decoder lid_props u_props (
    .i_clk, .i_sys_rst, .i_strobe, .i_register_select_line, .i_read_not_write, .o_data,
    .o_data_oe, .i_horizontal_pitch, .i_vertical_pitch, .i_char_mode, .i_cursor_enable,
    .o_row_length, .o_duty_divisor, .o_cursor_line, .o_start_address, .o_cursor_address,
    .o_dot_count, .o_cursor_visible, .o_busy
);

/* bench/lid_host_model.sv */
/* Host processor model on the 8-bit parallel bus: byte write, byte read, busy poll.
   Assumes the bench resolves the shared data bus from the decoder's output enable. */
`timescale 1ns/1ps
module lid_host_model (
    input wire logic i_clk,
    input wire logic [lid_pkg::DATA_W-1:0] i_bus,
    input wire logic i_bus_oe,
    output logic o_strobe,
    output logic o_register_select_line,
    output logic o_read_not_write,
    output logic [lid_pkg::DATA_W-1:0] o_data
);
    import lid_pkg::*;
    initial begin
        o_strobe = 1'b0;
        o_register_select_line = 1'b1;
        o_read_not_write = 1'b1;
        o_data = 8'h00;
    end
    // long setup and hold: pins cross two sync flops inside
    task automatic wr(input logic sel, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        o_register_select_line <= sel;
        o_read_not_write <= 1'b0;
        o_data <= d;
        @(posedge i_clk);
        o_strobe <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_strobe <= 1'b0;
        repeat (5) @(posedge i_clk);
        o_data <= ~d;
    endtask : wr
    task automatic rd(input logic sel, output logic [DATA_W-1:0] d);
        @(posedge i_clk);
        o_register_select_line <= sel;
        o_read_not_write <= 1'b1;
        @(posedge i_clk);
        o_strobe <= 1'b1;
        repeat (7) @(posedge i_clk);
        d = i_bus_oe ? i_bus : 'x;
        o_strobe <= 1'b0;
        repeat (5) @(posedge i_clk);
    endtask : rd
    task automatic idle();
        logic [DATA_W-1:0] s;
        s = 8'h80;
        for (int i = 0; i < 20 && s[BUSY_BIT] !== 1'b0; i++) begin
            rd(1'b1, s);
        end
    endtask : idle
    task automatic op(input logic [INSTR_W-1:0] code, input logic [DATA_W-1:0] d);
        idle();
        wr(1'b1, {4'h0, code});
        wr(1'b0, d);
    endtask : op
endmodule : lid_host_model

/* bench/lid_instruction_decoder_tb.sv */
/* Self-checking bench for the instruction decoder: settings, cursor counter, RAM and busy.
   Assumes the host model and the bound port checker are compiled alongside. */
`timescale 1ns/1ps
module lid_instruction_decoder_tb;
    import lid_pkg::*;
    logic i_clk;
    logic i_sys_rst;
    logic [3:0] hp, vp;
    logic cm, ce;
    wire h_strobe, h_sel, h_rnw, d_oe, vis, busy;
    wire [7:0] h_data, d_data, row, duty;
    wire [3:0] line;
    wire [15:0] start, caddr;
    wire [11:0] dots;
    wire [7:0] bus = d_oe ? d_data : h_data;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'hDC18;
    logic [7:0] mem [logic [15:0]];
    logic [15:0] cur;
    lid_host_model host (.i_clk(i_clk), .i_bus(bus), .i_bus_oe(d_oe), .o_strobe(h_strobe),
        .o_register_select_line(h_sel), .o_read_not_write(h_rnw), .o_data(h_data));
    lid_instruction_decoder DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_strobe(h_strobe),
        .i_register_select_line(h_sel), .i_read_not_write(h_rnw), .i_data(bus), .o_data(d_data),
        .o_data_oe(d_oe), .i_horizontal_pitch(hp), .i_vertical_pitch(vp), .i_char_mode(cm),
        .i_cursor_enable(ce), .o_row_length(row), .o_duty_divisor(duty), .o_cursor_line(line),
        .o_start_address(start), .o_cursor_address(caddr), .o_dot_count(dots),
        .o_cursor_visible(vis), .o_busy(busy));
    function automatic logic [7:0] bit_op(logic [7:0] b, logic [2:0] n, logic s);
        bit_op = b;
        bit_op[n] = s;
    endfunction : bit_op
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic set_cur(input logic [15:0] a);
        host.op(CODE_CURSOR_LOW, a[7:0]);
        host.op(CODE_CURSOR_HIGH, a[15:8]);
        host.idle();
        cur = a;
        chk("cursor load", a, caddr);
    endtask : set_cur
    initial begin
        i_clk = 1'b0;
        forever begin
            #25 i_clk = ~i_clk;
        end
    end
    initial begin
        #(50 * 30000);
        n_fail++;
        close_out();
    end
    initial begin : main
        logic [7:0] d, r;
        logic [15:0] a;
        logic [3:0] c;
        logic [3:0] undef [5];
        undef = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7};
        i_sys_rst = 1'b1;
        {hp, vp, cm, ce} = {4'h8, 4'h7, 2'b11};
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("reset settings", 16'h0000, {row, duty});
        chk("reset cursor", 16'h0000, caddr);
        for (int k = 0; k < 6; k++) begin
            d = 8'($random(seed));
            hp <= 4'h6 + 4'($unsigned($random(seed)) % 3);
            vp <= 4'($random(seed));
            {cm, ce} <= 2'($random(seed));
            host.op(CODE_ROW_LENGTH, {d[7:1], 1'b1});
            host.op(CODE_DUTY, k == 0 ? 8'h3F : ~d);
            host.op(CODE_CURSOR_LINE, d);
            host.op(CODE_START_LOW, d);
            host.op(CODE_START_HIGH, ~d);
            host.op(undef[k % 5], 8'hFF);
            host.idle();
            chk("row length", {8'h00, d[7:1], 1'b1}, {8'h00, row});
            chk("duty", {8'h00, k == 0 ? 8'h3F : ~d}, {8'h00, duty});
            chk("cursor line", {12'h000, d[3:0]}, {12'h000, line});
            chk("start", {~d, d}, start);
            chk("dots", {4'h0, hp} * {8'h00, d[7:1], 1'b1} + {12'h000, hp}, {4'h0, dots});
            chk("cursor shown", {15'h0000, cm & ce & (d[3:0] <= vp)}, {15'h0000, vis});
        end
        set_cur(16'h1280);
        host.op(CODE_CURSOR_LOW, 8'h00);
        host.idle();
        chk("low load carry", 16'h1300, caddr);
        for (int n = 0; n < 3; n++) begin
            a = {8'($random(seed)), 8'hFC};
            set_cur(a);
            host.wr(1'b1, {4'h0, CODE_RAM_WRITE});
            for (int i = 0; i < 8; i++) begin
                d = 8'($random(seed));
                host.wr(1'b0, d);
                host.idle();
                mem[cur] = d;
                cur++;
                chk("cursor after write", cur, caddr);
            end
            set_cur(a);
            for (int i = 0; i < 4; i++) begin
                c = 4'($random(seed));
                host.op(c[3] ? CODE_BIT_SET : CODE_BIT_CLEAR, {5'h00, c[2:0]});
                // bit job still running: busy pin must be up here
                chk("busy in bit op", 16'h0001, {15'h0000, busy});
                mem[cur] = bit_op(mem[cur], c[2:0], c[3]);
                cur++;
            end
            host.idle();
            chk("cursor after bit ops", cur, caddr);
            set_cur(a);
            host.wr(1'b1, {4'h0, CODE_RAM_READ});
            host.rd(1'b0, r);
            for (int i = 0; i < 8; i++) begin
                host.rd(1'b0, r);
                chk("ram read", {8'h00, mem[a + 16'(i)]}, {8'h00, r});
            end
            host.idle();
            chk("cursor after reads", a + 16'h0009, caddr);
            host.rd(1'b1, r);
            chk("status idle", 16'h0000, {8'h00, r});
            chk("busy pin idle", 16'h0000, {15'h0000, busy});
        end
        close_out();
    end
endmodule : lid_instruction_decoder_tb
